// File: rtl/flscc_core.sv
// status and configuration command core of a stacked serial flash die
// assumes array, die select and address logic on the same clock
// What this block does
// R1 - die identifier instruction shifts active die_identifier out; answers even when busy
// R2 - write enable instruction sets the write latch when not busy, one-byte frame
// R3 - host sets write latch before status writes, programs, erases, protection
// R4 - write enable ignored while volatile-status enable is pending
// R5 - volatile-status enable ignored while write latch is set
// R6 - volatile enable never sets latch; lets next status write change config bits
// R7 - write disable clears latch and pending volatile enable
// R8 - latch clears on power-up, status write, program/erase done, reset
// R9 - status reads return byte one, two, three; allowed busy; repeat till deselect
// R10 - 01 writes one or one then two; 31 writes two; 11 writes three
// R11 - only writable status fields change; other positions untouched
// R12 - security lock bits stay set once written to one, until reset
// R13 - status write needs prior write enable or volatile enable
// R14 - status write leaves suspend flags, latch and busy bit untouched
// R15 - status write ending off a byte boundary is rejected
// R16 - valid status write starts timed cycle; busy then clear, latch cleared
// R17 - hardware protected mode blocks status writes
// R18 - upper address read shifts register out msb first
// R19 - in three-byte mode upper byte comes from register; four-byte mode bypasses it
// R20 - upper address write needs latch set and one data byte
// R21 - upper address register resets to zero
// R22 - four-byte mode addresses overwrite upper address register
// R23 - latch and volatile enable exclusive; both clear on disable, reset, status write completion
module flscc_core (
  // clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       RESET_I,
  // serial pins
  input  wire logic       SCLK_I,
  input  wire logic       CS_N_I,
  input  wire logic       MOSI_I,
  input  wire logic       WP_N_I,
  output logic            MISO_O,
  output logic            MISO_OE_O,
  // array side
  input  wire logic [7:0] DIE_IDENTIFIER_I,
  input  wire logic       ARRAY_BUSY_I,
  input  wire logic       ARRAY_DONE_I,
  input  wire logic       SUS_A_I,
  input  wire logic       SUS_B_I,
  input  wire logic       ADDR4_VLD_I,
  input  wire logic [7:0] ADDR4_HI_I,
  // state out
  output logic [7:0]      STATUS1_O,
  output logic [7:0]      STATUS2_O,
  output logic [7:0]      STATUS3_O,
  output logic [7:0]      UPPER_ADDR_O,
  output logic [7:0]      ARRAY_HI_O
);
  typedef struct packed {
    flscc_pkg::flscc_st_t        st;
    logic [7:0]                  op;
    logic [1:0]                  nb;
    logic [7:0]                  d1;
    logic [7:0]                  d2;
    logic                        write_latch_flag;
    logic                        vwe;
    logic                        busy;
    logic [flscc_pkg::TW_W-1:0]  tw_cnt;
    logic [7:0]                  sr1;
    logic [7:0]                  sr2;
    logic [7:0]                  sr3;
    logic [7:0]                  ext;
    logic [7:0]                  hi;
    logic [1:0]                  wp_s;
    logic [7:0]                  o1;
    logic [7:0]                  o2;
    logic [7:0]                  o3;
    logic                        tx_load;
    logic [7:0]                  tx_byte;
  } flscc_core_t;

  flscc_core_t  q;
  flscc_core_t  n;
  flscc_link_if lk ();

  logic       busy_all;
  logic       hw_prot;
  logic       frame_end;
  logic       cnt_ok;
  logic       wsr_go;
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] s3;
  logic [7:0] rd_val;
  logic [7:0] lb_now;

  flscc_shift u_shift (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RESET_I),
    .sclk_i    (SCLK_I),
    .cs_n_i    (CS_N_I),
    .mosi_i    (MOSI_I),
    .miso_o    (MISO_O),
    .miso_oe_o (MISO_OE_O),
    .lk        (lk.shifter)
  );

  assign busy_all = q.busy | ARRAY_BUSY_I;
  assign lb_now = q.sr2 & flscc_pkg::SR2_LBMASK;

  // live status view
  always_comb begin
    s1 = q.sr1 & flscc_pkg::SR1_WMASK;
    s1[flscc_pkg::SR1_BUSY] = busy_all; // R14
    s1[flscc_pkg::SR1_WEL] = q.write_latch_flag; // R14
    s2 = q.sr2 & flscc_pkg::SR2_WMASK;
    s2[flscc_pkg::SR2_SUSA] = SUS_A_I; // R14
    s2[flscc_pkg::SR2_SUSB] = SUS_B_I; // R14
    s3 = q.sr3 & flscc_pkg::SR3_WMASK;
  end

  assign hw_prot = q.sr2[flscc_pkg::SR2_STATUS_PROTECT_BIT_HIGH]
                 | (q.sr1[flscc_pkg::SR1_STATUS_PROTECT_BIT_LOW] & ~q.wp_s[1]); // R17
  assign frame_end = lk.cs_end && (q.st == flscc_pkg::ST_DATA) && !lk.partial; // R15

  // byte count per write opcode
  always_comb begin
    cnt_ok = 1'b0;
    if (q.op == flscc_pkg::OP_WRS1) begin
      cnt_ok = (q.nb == 2'h1) || (q.nb == 2'h2); // R10
    end else if (q.op == flscc_pkg::OP_WRS2 || q.op == flscc_pkg::OP_WRS3) begin
      cnt_ok = (q.nb == 2'h1); // R10
    end
  end

  assign wsr_go = frame_end && cnt_ok && (q.write_latch_flag || q.vwe) // R13
                && !hw_prot && !busy_all; // R17

  // answer byte for read opcodes
  always_comb begin
    rd_val = 8'h00;
    if (q.op == flscc_pkg::OP_RDS1) begin
      rd_val = s1; // R9
    end else if (q.op == flscc_pkg::OP_RDS2) begin
      rd_val = s2; // R9
    end else if (q.op == flscc_pkg::OP_RDS3) begin
      rd_val = s3; // R9
    end else if (q.op == flscc_pkg::OP_DIE) begin
      rd_val = DIE_IDENTIFIER_I; // R1
    end else if (q.op == flscc_pkg::OP_RDEXT) begin
      rd_val = q.ext; // R18
    end
  end

  always_comb begin
    n = q;
    n.tx_load = 1'b0;
    n.wp_s = {q.wp_s[0], WP_N_I};
    n.o1 = s1;
    n.o2 = s2;
    n.o3 = s3;
    // frame sequencing
    case (q.st)
      flscc_pkg::ST_OPC: begin
        if (lk.byte_vld) begin
          n.op = lk.rx_byte;
          n.nb = 2'h0;
          n.st = flscc_pkg::ST_DATA;
          if (lk.rx_byte == flscc_pkg::OP_RDS1 || lk.rx_byte == flscc_pkg::OP_RDS2
              || lk.rx_byte == flscc_pkg::OP_RDS3 || lk.rx_byte == flscc_pkg::OP_DIE
              || lk.rx_byte == flscc_pkg::OP_RDEXT) begin
            n.st = flscc_pkg::ST_READ;
          end
        end
      end
      flscc_pkg::ST_READ: begin
        if (lk.byte_vld || q.nb == 2'h0) begin
          n.tx_load = 1'b1; // R1
          n.tx_byte = rd_val; // R9
          n.nb = 2'h1;
        end
      end
      flscc_pkg::ST_DATA: begin
        if (lk.byte_vld) begin
          if (q.nb == 2'h0) begin
            n.d1 = lk.rx_byte;
          end else if (q.nb == 2'h1) begin
            n.d2 = lk.rx_byte;
          end
          if (q.nb != 2'h3) begin
            n.nb = q.nb + 2'h1;
          end
        end
      end
      default: begin
        n.st = flscc_pkg::ST_OPC;
      end
    endcase
    if (lk.cs_start || lk.cs_end) begin
      n.st = flscc_pkg::ST_OPC;
    end
    // self-timed status write cycle
    if (q.busy) begin
      if (q.tw_cnt == '0) begin
        n.busy = 1'b0; // R16
        n.write_latch_flag = 1'b0; // R8
        n.vwe = 1'b0; // R23
      end else begin
        n.tw_cnt = q.tw_cnt - 1'b1;
      end
    end
    if (ARRAY_DONE_I) begin
      n.write_latch_flag = 1'b0; // R8
    end
    // single-byte instructions, run on deselect
    if (frame_end && q.nb == 2'h0) begin
      if (q.op == flscc_pkg::OP_WREN && !q.vwe && !busy_all) begin
        n.write_latch_flag = 1'b1; // R2 R4 R23
      end else if (q.op == flscc_pkg::OP_VWREN && !q.write_latch_flag && !busy_all) begin
        n.vwe = 1'b1; // R5 R6 R23
      end else if (q.op == flscc_pkg::OP_WRDI) begin
        n.write_latch_flag = 1'b0; // R7
        n.vwe = 1'b0; // R7
      end
    end
    // upper address byte write
    if (frame_end && q.op == flscc_pkg::OP_WREXT && q.nb == 2'h1
        && q.write_latch_flag && !busy_all) begin
      n.ext = q.d1; // R20 R3
    end
    // status write
    if (wsr_go) begin
      if (q.op == flscc_pkg::OP_WRS1) begin
        n.sr1 = (q.sr1 & ~flscc_pkg::SR1_WMASK) | (q.d1 & flscc_pkg::SR1_WMASK); // R11
        if (q.nb == 2'h2) begin
          n.sr2 = (q.sr2 & ~flscc_pkg::SR2_WMASK) | (q.d2 & flscc_pkg::SR2_WMASK) | lb_now; // R12
        end
      end else if (q.op == flscc_pkg::OP_WRS2) begin
        n.sr2 = (q.sr2 & ~flscc_pkg::SR2_WMASK) | (q.d1 & flscc_pkg::SR2_WMASK) | lb_now; // R12
      end else begin
        n.sr3 = (q.sr3 & ~flscc_pkg::SR3_WMASK) | (q.d1 & flscc_pkg::SR3_WMASK); // R11
      end
      n.busy = 1'b1; // R16
      n.tw_cnt = flscc_pkg::TW_W'(flscc_pkg::TW_CYC - 1);
    end
    // four-byte mode addresses refresh the upper byte
    if (q.sr3[flscc_pkg::SR3_ADS] && ADDR4_VLD_I) begin
      n.ext = ADDR4_HI_I; // R22
    end
    n.hi = q.sr3[flscc_pkg::SR3_ADS] ? ADDR4_HI_I : q.ext; // R19
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      q <= '0;
      q.sr1 <= flscc_pkg::SR1_RST;
      q.sr2 <= flscc_pkg::SR2_RST;
      q.sr3 <= flscc_pkg::SR3_RST;
      q.ext <= flscc_pkg::EXT_RST; // R21
      q.wp_s <= 2'h3;
    end else begin
      q <= n;
    end
  end

  assign lk.tx_load = q.tx_load;
  assign lk.tx_byte = q.tx_byte;
  assign STATUS1_O = q.o1;
  assign STATUS2_O = q.o2;
  assign STATUS3_O = q.o3;
  assign UPPER_ADDR_O = q.ext;
  assign ARRAY_HI_O = q.hi;

  // checks
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);

  logic wren_run;
  logic vwren_run;
  assign wren_run = frame_end && q.nb == 2'h0 && q.op == flscc_pkg::OP_WREN;
  assign vwren_run = frame_end && q.nb == 2'h0 && q.op == flscc_pkg::OP_VWREN;

  sequence seq_wsr_go;
    wsr_go;
  endsequence

  sequence seq_cycle_end;
    q.busy && q.tw_cnt == '0;
  endsequence

  a_wren_sets_latch: assert property (wren_run && !q.vwe && !busy_all |=> q.write_latch_flag) // R2
    else $error("write enable did not set latch");
  a_wren_blocked: assert property (wren_run && q.vwe && !q.write_latch_flag |=> !q.write_latch_flag) // R4
    else $error("write enable taken while volatile enable pending");
  a_vwren_blocked: assert property (vwren_run && q.write_latch_flag && !ARRAY_DONE_I && !busy_all |=> !q.vwe && q.write_latch_flag) // R5
    else $error("volatile enable taken while latch set");
  a_vwren_no_latch: assert property (vwren_run && !q.write_latch_flag && !busy_all |=> q.vwe && !q.write_latch_flag) // R6
    else $error("volatile enable misbehaved");
  a_wrdi_clears: assert property (frame_end && q.nb == 2'h0 && q.op == flscc_pkg::OP_WRDI
                                  |=> !q.write_latch_flag && !q.vwe) // R7
    else $error("write disable left enable set");
  a_wsr_busy_now: assert property (seq_wsr_go |=> q.busy && q.tw_cnt == flscc_pkg::TW_W'(flscc_pkg::TW_CYC - 1)) // R16
    else $error("status write cycle not started");
  a_wsr_end_clear: assert property (seq_cycle_end |=> !q.busy && !q.write_latch_flag && !q.vwe) // R16
    else $error("status write cycle end wrong");
  a_partial_reject: assert property (lk.cs_end && lk.partial && !q.busy |=> !q.busy && $stable(q.sr1)) // R15
    else $error("partial status write executed");
  a_hw_protect: assert property (frame_end && hw_prot && !q.busy |=> !q.busy && $stable(q.sr2)) // R17
    else $error("status write ran while protected");
  a_no_enable: assert property (frame_end && !q.write_latch_flag && !q.vwe && !q.busy |=> !q.busy) // R13
    else $error("status write ran without enable");
  a_lock_sticky: assert property (lb_now != 8'h00 |=> (lb_now & $past(lb_now)) == $past(lb_now)) // R12
    else $error("lock bit cleared");
  a_status_repeat: assert property (q.st == flscc_pkg::ST_READ && lk.byte_vld && !lk.cs_end
                                    |=> q.tx_load ##0 q.tx_byte == $past(rd_val)) // R9
    else $error("status read not repeated");
  a_ext_follow: assert property (ADDR4_VLD_I && q.sr3[flscc_pkg::SR3_ADS] |=> q.ext == $past(ADDR4_HI_I)) // R22
    else $error("upper address not refreshed");
  a_hi_select: assert property (!q.sr3[flscc_pkg::SR3_ADS] && $stable(q.ext) |=> ARRAY_HI_O == $past(q.ext)) // R19
    else $error("upper address not used in three-byte mode");
  a_exclusive: assert property (!(q.write_latch_flag && q.vwe)) // R23
    else $error("latch and volatile enable both set");
endmodule

// File: rtl/flscc_pkg.sv
// constants, field layout and types of the status/config command block
// assumes one serial flash lane, sampled by the system clock
package flscc_pkg;
  // instruction codes
  localparam logic [7:0] OP_DIE   = 8'hF8;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDS1  = 8'h05;
  localparam logic [7:0] OP_RDS2  = 8'h35;
  localparam logic [7:0] OP_RDS3  = 8'h15;
  localparam logic [7:0] OP_WRS1  = 8'h01;
  localparam logic [7:0] OP_WRS2  = 8'h31;
  localparam logic [7:0] OP_WRS3  = 8'h11;
  localparam logic [7:0] OP_RDEXT = 8'hC8;
  localparam logic [7:0] OP_WREXT = 8'hC5;
  // status register one fields
  localparam int SR1_BUSY = 0;
  localparam int SR1_WEL  = 1;
  localparam int SR1_STATUS_PROTECT_BIT_LOW = 7;
  // status register two fields
  localparam int SR2_STATUS_PROTECT_BIT_HIGH = 0;
  localparam int SR2_QE   = 1;
  localparam int SR2_SUSB = 2;
  localparam int SR2_SUSA = 7;
  // status register three fields
  localparam int SR3_ADS  = 0;
  // writable masks and lock field
  localparam logic [7:0] SR1_WMASK  = 8'hFC;
  localparam logic [7:0] SR2_WMASK  = 8'h7B;
  localparam logic [7:0] SR3_WMASK  = 8'hE3;
  localparam logic [7:0] SR2_LBMASK = 8'h38;
  // reset values
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam logic [7:0] SR2_RST = 8'h00;
  localparam logic [7:0] SR3_RST = 8'h00;
  localparam logic [7:0] EXT_RST = 8'h00;
  // self-timed status write
  localparam int CLK_NS = 8;
  localparam int TW_NS  = 4000;
  localparam int TW_CYC = (TW_NS + CLK_NS - 1) / CLK_NS;
  localparam int TW_W   = 10;
  typedef enum logic [1:0] {ST_OPC, ST_READ, ST_DATA} flscc_st_t;
endpackage

// File: rtl/flscc_link_if.sv
// byte-level link between serial shifter and command core
// assumes both ends on the system clock
interface flscc_link_if;
  logic       byte_vld;
  logic [7:0] rx_byte;
  logic       cs_start;
  logic       cs_end;
  logic       partial;
  logic       tx_load;
  logic [7:0] tx_byte;
  modport shifter (output byte_vld, rx_byte, cs_start, cs_end, partial,
                   input  tx_load, tx_byte);
  modport core    (input  byte_vld, rx_byte, cs_start, cs_end, partial,
                   output tx_load, tx_byte);
endinterface

// File: rtl/flscc_shift.sv
// serial shifter: syncs pins, finds clock edges, packs bytes
// assumes serial clock well below a quarter of the system clock
module flscc_shift (
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // pins
  input  wire logic     sclk_i,
  input  wire logic     cs_n_i,
  input  wire logic     mosi_i,
  output logic          miso_o,
  output logic          miso_oe_o,
  // byte link
  flscc_link_if.shifter lk
);
  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] cs_s;
    logic [1:0] mo_s;
    logic       sck_d;
    logic       cs_d;
    logic       in_frame;
    logic [2:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic       byte_vld;
    logic       cs_start;
    logic       cs_end;
    logic       partial;
    logic       miso;
    logic       oe;
  } flscc_sh_t;

  flscc_sh_t q;
  flscc_sh_t n;
  logic      rise;
  logic      fall;
  logic      sel;

  always_comb begin
    n = q;
    n.sck_s = {q.sck_s[0], sclk_i};
    n.cs_s = {q.cs_s[0], cs_n_i};
    n.mo_s = {q.mo_s[0], mosi_i};
    n.sck_d = q.sck_s[1];
    n.cs_d = q.cs_s[1];
    rise = q.sck_s[1] & ~q.sck_d;
    fall = ~q.sck_s[1] & q.sck_d;
    sel = ~q.cs_s[1];
    n.byte_vld = 1'b0;
    n.cs_start = ~q.cs_s[1] & q.cs_d;
    n.cs_end = q.cs_s[1] & ~q.cs_d & q.in_frame;
    n.partial = (q.cnt != 3'h0);
    n.oe = sel;
    if (n.cs_start) begin
      n.in_frame = 1'b1;
      n.cnt = 3'h0;
    end
    if (n.cs_end) begin
      n.in_frame = 1'b0;
    end
    if (sel && rise) begin
      n.rx = {q.rx[6:0], q.mo_s[1]};
      n.cnt = q.cnt + 3'h1;
      n.byte_vld = (q.cnt == 3'h7);
    end
    // msb first on falling edges
    if (sel && fall) begin
      n.miso = q.tx[7];
      n.tx = {q.tx[6:0], 1'b0};
    end
    if (lk.tx_load) begin
      n.tx = lk.tx_byte;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cs_s <= 2'h3;
      q.cs_d <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign lk.byte_vld = q.byte_vld;
  assign lk.rx_byte = q.rx;
  assign lk.cs_start = q.cs_start;
  assign lk.cs_end = q.cs_end;
  assign lk.partial = q.partial;
  assign miso_o = q.miso;
  assign miso_oe_o = q.oe;
endmodule

// File: bench/flscc_host_model.sv
// serial host model: drives select, clock and data in mode 0
// assumes the system clock of the block; changes pins at its falling edge
module flscc_host_model (
  // clock
  input  wire logic clk_i,
  // serial pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one frame, msb first, 80 ns serial period; miso taken at each rise
  task automatic frame(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi_o = tx[i];
      gap(5);
      sclk_o = 1'b1;
      rx = {rx[30:0], miso_i};
      gap(5);
      sclk_o = 1'b0;
    end
    gap(5);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    gap(8);
  endtask
endmodule

// File: bench/testbench.sv
// self-checking bench of the status and configuration command block
// assumes the host model drives the serial pins
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        wp_n;
  logic        busy;
  logic        done;
  logic        sus_a;
  logic        sus_b;
  logic        a4_vld;
  logic [7:0]  die;
  logic [7:0]  a4_hi;
  logic [7:0]  s1;
  logic [7:0]  s2;
  logic [7:0]  s3;
  logic [7:0]  upper;
  logic [7:0]  arr_hi;
  logic [31:0] rx;
  logic [15:0] rd2;
  int errors = 0;
  int total_checks = 0;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  flscc_core dut (
    .CLK_SYS_I   (clk),
    .RESET_I     (rst),
    .SCLK_I      (sclk),
    .CS_N_I      (cs_n),
    .MOSI_I      (mosi),
    .WP_N_I      (wp_n),
    .MISO_O      (miso),
    .MISO_OE_O   (miso_oe),
    .DIE_IDENTIFIER_I    (die),
    .ARRAY_BUSY_I(busy),
    .ARRAY_DONE_I(done),
    .SUS_A_I     (sus_a),
    .SUS_B_I     (sus_b),
    .ADDR4_VLD_I (a4_vld),
    .ADDR4_HI_I  (a4_hi),
    .STATUS1_O   (s1),
    .STATUS2_O   (s2),
    .STATUS3_O   (s3),
    .UPPER_ADDR_O(upper),
    .ARRAY_HI_O  (arr_hi)
  );

  flscc_host_model host (
    .clk_i (clk),
    .sclk_o(sclk),
    .cs_n_o(cs_n),
    .mosi_o(mosi),
    .miso_i(miso)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    host.frame(8, {24'h0, op}, rx);
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    host.frame(16, {16'h0, op, d}, rx);
  endtask

  // opcode then two data bytes out; the second shows the repeat
  task automatic rd(input logic [7:0] op);
    host.frame(24, {8'h0, op, 16'h0}, rx);
    rd2 = rx[15:0];
  endtask

  // self-timed cycle: busy near its end, then clear within a bound
  task automatic wait_wip();
    int n;
    n = 0;
    host.gap(450);
    check({7'h0, s1[0]}, 8'h01);
    while (s1[0] !== 1'b0 && n < 100) begin
      host.gap(1);
      n++;
    end
    if (n >= 100) begin
      errors++;
      $display("CHECK FAILED at %0t: timed cycle never ended", $time);
      stop_test();
    end
  endtask

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, errors);
  endtask

  initial begin
    logic [7:0] ops[3];
    logic [7:0] exps[3];
    rst = 1'b1;
    wp_n = 1'b1;
    busy = 1'b0;
    done = 1'b0;
    sus_a = 1'b0;
    sus_b = 1'b0;
    a4_vld = 1'b0;
    die = 8'h00;
    a4_hi = 8'h00;
    host.gap(20);
    rst = 1'b0;
    host.gap(5);
    // reset values
    check(s1, 8'h00);
    check(upper, flscc_pkg::EXT_RST);
    check({7'h0, miso_oe}, 8'h00);
    rd(flscc_pkg::OP_RDEXT);
    check(rd2[15:8], 8'h00);
    test_end("reset");
    // die_identifier and status while array busy
    die = 8'h5A;
    busy = 1'b1;
    // output enable must stand while selected
    fork
      rd(flscc_pkg::OP_DIE);
      begin
        host.gap(20);
        check({7'h0, miso_oe}, 8'h01);
      end
    join
    check(rd2[15:8], 8'h5A);
    cmd(flscc_pkg::OP_WREN);
    rd(flscc_pkg::OP_RDS1);
    check(rd2[15:8], 8'h01);
    check(rd2[7:0], 8'h01);
    busy = 1'b0;
    host.gap(3);
    test_end("busy");
    // latch, ignored volatile enable, timed write
    cmd(flscc_pkg::OP_WREN);
    check(s1, 8'h02);
    cmd(flscc_pkg::OP_VWREN);
    check(s1, 8'h02);
    wr(flscc_pkg::OP_WRS1, 8'hFF);
    check(s1, 8'hFF);
    wait_wip();
    check(s1, 8'hFC);
    wr(flscc_pkg::OP_WRS1, 8'h00);
    check(s1, 8'hFC);
    test_end("latch");
    // two-byte write, read-only positions, lock bits, all three reads
    cmd(flscc_pkg::OP_WREN);
    host.frame(24, {8'h0, flscc_pkg::OP_WRS1, 8'h00, 8'hFE}, rx);
    wait_wip();
    check(s2, 8'h7A);
    ops = '{flscc_pkg::OP_RDS1, flscc_pkg::OP_RDS2, flscc_pkg::OP_RDS3};
    exps = '{8'h00, 8'h7A, 8'h00};
    for (int i = 0; i < 3; i++) begin
      rd(ops[i]);
      check(rd2[15:8], exps[i]);
      check(rd2[7:0], exps[i]);
    end
    cmd(flscc_pkg::OP_WREN);
    wr(flscc_pkg::OP_WRS2, 8'h00);
    wait_wip();
    check(s2, 8'h38);
    sus_a = 1'b1;
    sus_b = 1'b1;
    host.gap(3);
    check(s2, 8'hBC);
    sus_a = 1'b0;
    sus_b = 1'b0;
    test_end("status2");
    // write ending off a byte boundary
    cmd(flscc_pkg::OP_WREN);
    host.frame(12, {20'h0, flscc_pkg::OP_WRS1, 4'hF}, rx);
    check(s1, 8'h02);
    cmd(flscc_pkg::OP_WRDI);
    check(s1, 8'h00);
    test_end("partial");
    // volatile enable path
    cmd(flscc_pkg::OP_VWREN);
    cmd(flscc_pkg::OP_WREN);
    check(s1, 8'h00);
    wr(flscc_pkg::OP_WRS1, 8'h1C);
    check(s1, 8'h1D);
    wait_wip();
    check(s1, 8'h1C);
    cmd(flscc_pkg::OP_VWREN);
    cmd(flscc_pkg::OP_WRDI);
    wr(flscc_pkg::OP_WRS1, 8'h00);
    check(s1, 8'h1C);
    test_end("volatile");
    // hardware protection
    cmd(flscc_pkg::OP_WREN);
    wr(flscc_pkg::OP_WRS1, 8'h80);
    wait_wip();
    wp_n = 1'b0;
    cmd(flscc_pkg::OP_WREN);
    wr(flscc_pkg::OP_WRS1, 8'h00);
    check(s1 & 8'hFD, 8'h80);
    wp_n = 1'b1;
    host.gap(3);
    wr(flscc_pkg::OP_WRS1, 8'h00);
    wait_wip();
    check(s1, 8'h00);
    test_end("protect");
    // upper address register and four-byte mode
    cmd(flscc_pkg::OP_WREN);
    wr(flscc_pkg::OP_WREXT, 8'h81);
    check(upper, 8'h81);
    check(arr_hi, 8'h81);
    rd(flscc_pkg::OP_RDEXT);
    check(rd2[15:8], 8'h81);
    cmd(flscc_pkg::OP_WRDI);
    wr(flscc_pkg::OP_WREXT, 8'h11);
    check(upper, 8'h81);
    cmd(flscc_pkg::OP_WREN);
    wr(flscc_pkg::OP_WRS3, 8'hFF);
    wait_wip();
    check(s3, 8'hE3);
    a4_hi = 8'h3C;
    a4_vld = 1'b1;
    host.gap(1);
    a4_vld = 1'b0;
    host.gap(3);
    check(upper, 8'h3C);
    a4_hi = 8'h55;
    host.gap(3);
    check(arr_hi, 8'h55);
    cmd(flscc_pkg::OP_WREN);
    wr(flscc_pkg::OP_WRS3, 8'h00);
    wait_wip();
    check(arr_hi, 8'h3C);
    test_end("address");
    // completion pulse from the array clears the latch
    cmd(flscc_pkg::OP_WREN);
    done = 1'b1;
    host.gap(1);
    done = 1'b0;
    host.gap(3);
    check(s1, 8'h00);
    // reset in mid-run
    cmd(flscc_pkg::OP_WREN);
    wr(flscc_pkg::OP_WREXT, 8'h77);
    rst = 1'b1;
    host.gap(3);
    rst = 1'b0;
    host.gap(5);
    check(upper, 8'h00);
    check(s2, 8'h00);
    test_end("reset again");
    stop_test();
  end
endmodule
